// ===== hdl/omr_pkg.sv
// Package for the occupancy mode and restart state control block
package omr_pkg;

	// Operating modes
	typedef enum logic [1:0] {
		OMR_MODE_FULL_AUTO = 2'b00,
		OMR_MODE_MANUAL_START_AUTO_END = 2'b01,
		OMR_MODE_AUTO_START_MANUAL_END = 2'b10
	} omr_mode_e;

	// Application types
	typedef enum logic [1:0] {
		OMR_APP_SINGLE = 2'b00,
		OMR_APP_MAIN = 2'b01,
		OMR_APP_EXTENSION = 2'b10
	} omr_app_e;

	// Restart setting after supply return
	typedef enum logic [0:0] {
		OMR_RESTART_NO_REACTION = 1'b0,
		OMR_RESTART_DISABLING = 1'b1
	} omr_restart_e;

	// Block state
	typedef enum logic [1:0] {
		OMR_ST_IDLE = 2'b00,
		OMR_ST_ARMED = 2'b01,
		OMR_ST_DETECT = 2'b10,
		OMR_ST_DISABLED = 2'b11
	} omr_state_e;

	// Configuration carried as one packed word
	typedef struct packed {
		omr_mode_e mode;
		omr_app_e app;
		omr_restart_e restart;
		logic light_ctrl;
		logic first_function_block;
		logic send_on_disable;
	} omr_cfg_s;

	// Output telegram pulses
	typedef struct packed {
		logic detect_start;
		logic detect_end;
		logic disable_start;
		logic disable_end;
	} omr_tx_s;

	// APB register map (byte addresses)
	localparam logic [7:0] OMR_CTRL_ADDR = 8'h00;
	localparam logic [7:0] OMR_STATUS_ADDR = 8'h04;
	localparam logic [7:0] OMR_HOLD_ADDR = 8'h08;

	// CTRL field positions
	localparam int OMR_CTRL_MODE_LSB = 0;
	localparam int OMR_CTRL_APP_LSB = 2;
	localparam int OMR_CTRL_RESTART_BIT = 4;
	localparam int OMR_CTRL_LIGHT_BIT = 5;
	localparam int OMR_CTRL_FB1_BIT = 6;
	localparam int OMR_CTRL_SENDDIS_BIT = 7;
	localparam int OMR_CTRL_DISEND_BIT = 8;

	// STATUS field positions
	localparam int OMR_STAT_STATE_LSB = 0;
	localparam int OMR_STAT_TIMER_BIT = 2;
	localparam int OMR_STAT_PRES_BIT = 3;
	localparam int OMR_STAT_SAVED_LSB = 4;

	// Reset values
	localparam logic [8:0] OMR_CTRL_RESET = 9'h000;
	localparam int OMR_HOLD_WIDTH = 32;
	localparam logic [31:0] OMR_HOLD_RESET = 32'h0000_03e8;

	// Hold-off tick period in ns, and its cycle count at 250 MHz
	localparam int OMR_CLK_MHZ = 250;
	localparam int OMR_TICK_NS = 1000;
	localparam int OMR_TICK_CYCLES = (OMR_TICK_NS * OMR_CLK_MHZ) / 1000;

endpackage : omr_pkg

// ===== hdl/omr_fsm.sv
// Occupancy mode and supply-return restart state control, with APB registers
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
module omr_fsm #(
	parameter int HOLD_WIDTH = omr_pkg::OMR_HOLD_WIDTH,
	parameter int TICK_CYCLES = omr_pkg::OMR_TICK_CYCLES
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic motion_i,
	input wire logic manual_on_i,
	input wire logic manual_off_i,
	input wire logic supply_return_i,
	output omr_pkg::omr_tx_s tx_o,
	output logic presence_o,
	output logic detecting_o
);
	import omr_pkg::*;

	localparam int TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

	// Pin synchronisers
	logic motion_s1;
	logic motion_s2;
	logic supply_s1;
	logic supply_s2;
	logic supply_s3;

	// Configuration and state
	omr_cfg_s cfg;
	logic [HOLD_WIDTH-1:0] hold_time;
	omr_state_e state;
	omr_state_e saved_state;
	logic [HOLD_WIDTH-1:0] hold_cnt;
	logic hold_run;
	logic [TICK_W-1:0] tick_cnt;
	logic tick;
	logic restart_pulse;
	logic restart_allowed;
	logic disable_req;
	logic disable_end_req;
	omr_tx_s next_tx;
	omr_state_e next_state;

	// Bus access helpers
	logic apb_wr;
	logic apb_rd;
	logic addr_ok;
	logic [31:0] next_prdata;

	// Two-flop sync; edge detect reads only the second stage onward
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			motion_s1 <= 1'b0;
			motion_s2 <= 1'b0;
			supply_s1 <= 1'b0;
			supply_s2 <= 1'b0;
			supply_s3 <= 1'b0;
		end else begin
			motion_s1 <= motion_i;
			motion_s2 <= motion_s1;
			supply_s1 <= supply_return_i;
			supply_s2 <= supply_s1;
			supply_s3 <= supply_s2;
		end
	end

	assign restart_pulse = supply_s2 && !supply_s3;

	assign restart_allowed = (cfg.app != OMR_APP_EXTENSION);

	assign apb_wr = psel_i && penable_i && pwrite_i;
	assign apb_rd = psel_i && !penable_i && !pwrite_i;
	assign addr_ok = (paddr_i == OMR_CTRL_ADDR) || (paddr_i == OMR_STATUS_ADDR) || (paddr_i == OMR_HOLD_ADDR);
	assign disable_req = apb_wr && (paddr_i == OMR_CTRL_ADDR) && pwdata_i[OMR_CTRL_DISEND_BIT];
	assign disable_end_req = disable_req && (state == OMR_ST_DISABLED);

	// Configuration register writes
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			cfg <= omr_cfg_s'(OMR_CTRL_RESET[7:0]);
			hold_time <= HOLD_WIDTH'(OMR_HOLD_RESET);
		end else if (apb_wr && paddr_i == OMR_CTRL_ADDR) begin
			cfg.app <= omr_app_e'(pwdata_i[OMR_CTRL_APP_LSB +: 2]);
			cfg.restart <= omr_restart_e'(pwdata_i[OMR_CTRL_RESTART_BIT]);
			cfg.light_ctrl <= pwdata_i[OMR_CTRL_LIGHT_BIT];
			cfg.first_function_block <= pwdata_i[OMR_CTRL_FB1_BIT];
			cfg.send_on_disable <= pwdata_i[OMR_CTRL_SENDDIS_BIT];
			if (!(pwdata_i[OMR_CTRL_LIGHT_BIT] && pwdata_i[OMR_CTRL_MODE_LSB +: 2] == 2'(OMR_MODE_AUTO_START_MANUAL_END))
					&& pwdata_i[OMR_CTRL_MODE_LSB +: 2] != 2'b11) begin
				cfg.mode <= omr_mode_e'(pwdata_i[OMR_CTRL_MODE_LSB +: 2]);
			end
		end else if (apb_wr && paddr_i == OMR_HOLD_ADDR) begin
			hold_time <= pwdata_i[HOLD_WIDTH-1:0];
		end
	end

	// Base tick divider for the hold-off timer
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			tick_cnt <= '0;
			tick <= 1'b0;
		end else if (tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
			tick_cnt <= '0;
			tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 1'b1;
			tick <= 1'b0;
		end
	end

	// Next-state logic; restart has priority over all events
	always_comb begin
		next_state = state;
		next_tx = '0;
		if (restart_pulse && restart_allowed) begin
			// restart setting picks the disabled state or the basic state
			if (cfg.restart == OMR_RESTART_DISABLING) begin
				next_state = OMR_ST_DISABLED;
				next_tx.disable_start = cfg.send_on_disable;
			end else begin
				next_state = (cfg.mode == OMR_MODE_MANUAL_START_AUTO_END) ? OMR_ST_IDLE : OMR_ST_ARMED;
			end
		end else begin
			case (state)
				OMR_ST_IDLE: begin
					if (manual_on_i || cfg.mode != OMR_MODE_MANUAL_START_AUTO_END) begin
						next_state = manual_on_i ? OMR_ST_DETECT : OMR_ST_ARMED;
						next_tx.detect_start = manual_on_i;
					end
				end
				OMR_ST_ARMED: begin
					if (cfg.mode == OMR_MODE_MANUAL_START_AUTO_END) begin
						next_state = manual_on_i ? OMR_ST_DETECT : OMR_ST_IDLE;
						next_tx.detect_start = manual_on_i;
					end else if (motion_s2 || manual_on_i) begin
						next_state = OMR_ST_DETECT;
						next_tx.detect_start = 1'b1;
					end
				end
				OMR_ST_DETECT: begin
					if (manual_off_i) begin
						next_tx.detect_end = 1'b1;
						next_state = (cfg.mode == OMR_MODE_MANUAL_START_AUTO_END) ? OMR_ST_IDLE : OMR_ST_ARMED;
					end else if (hold_run && hold_cnt == '0 && tick) begin
						next_tx.detect_end = 1'b1;
						next_state = (cfg.mode == OMR_MODE_MANUAL_START_AUTO_END) ? OMR_ST_IDLE : OMR_ST_ARMED;
					end
				end
				OMR_ST_DISABLED: begin
					if (disable_end_req) begin
						next_tx.disable_end = 1'b1;
						next_state = saved_state;
					end
				end
				default: next_state = OMR_ST_IDLE;
			endcase
		end
	end

	// State, saved state and telegram outputs
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			state <= OMR_ST_IDLE;
			saved_state <= OMR_ST_IDLE;
			tx_o <= '0;
			detecting_o <= 1'b0;
		end else begin
			state <= next_state;
			tx_o <= next_tx;
			detecting_o <= (next_state == OMR_ST_DETECT);
			// basic state is the one to restore
			if (restart_pulse && restart_allowed && cfg.restart == OMR_RESTART_DISABLING) begin
				saved_state <= (cfg.mode == OMR_MODE_MANUAL_START_AUTO_END) ? OMR_ST_IDLE : OMR_ST_ARMED;
			end else if (disable_req && state != OMR_ST_DISABLED) begin
				saved_state <= state;
			end
		end
	end

	// Hold-off timer: reloaded on each motion while detecting, held clear in auto-start manual-end mode
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			hold_cnt <= '0;
			hold_run <= 1'b0;
		end else if (restart_pulse && restart_allowed) begin
			hold_run <= 1'b0;
			hold_cnt <= '0;
		end else if (next_state == OMR_ST_DETECT && cfg.mode != OMR_MODE_AUTO_START_MANUAL_END) begin
			if (state != OMR_ST_DETECT || motion_s2) begin
				hold_run <= 1'b1;
				hold_cnt <= hold_time;
			end else if (tick && hold_cnt != '0) begin
				hold_cnt <= hold_cnt - 1'b1;
			end
		end else begin
			hold_run <= 1'b0;
			hold_cnt <= '0;
		end
	end

	// Presence indication to light control
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			presence_o <= 1'b0;
		end else if (restart_pulse && restart_allowed) begin
			presence_o <= 1'b0;
		end else begin
			// light control only on first block
			presence_o <= cfg.light_ctrl && cfg.first_function_block && (next_state == OMR_ST_DETECT);
		end
	end

	// APB read data, zero wait states
	always_comb begin
		next_prdata = '0;
		case (paddr_i)
			OMR_CTRL_ADDR: begin
				next_prdata[OMR_CTRL_MODE_LSB +: 2] = cfg.mode;
				next_prdata[OMR_CTRL_APP_LSB +: 2] = cfg.app;
				next_prdata[OMR_CTRL_RESTART_BIT] = cfg.restart;
				next_prdata[OMR_CTRL_LIGHT_BIT] = cfg.light_ctrl;
				next_prdata[OMR_CTRL_FB1_BIT] = cfg.first_function_block;
				next_prdata[OMR_CTRL_SENDDIS_BIT] = cfg.send_on_disable;
			end
			OMR_STATUS_ADDR: begin
				next_prdata[OMR_STAT_STATE_LSB +: 2] = state;
				next_prdata[OMR_STAT_TIMER_BIT] = hold_run;
				next_prdata[OMR_STAT_PRES_BIT] = presence_o;
				next_prdata[OMR_STAT_SAVED_LSB +: 2] = saved_state;
			end
			OMR_HOLD_ADDR: next_prdata[HOLD_WIDTH-1:0] = hold_time;
			default: next_prdata = '0;
		endcase
	end

	// Data is set in the setup cycle so pready can be high in access
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			prdata_o <= '0;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			if (apb_rd) begin
				prdata_o <= next_prdata;
			end
			pready_o <= psel_i && !penable_i;
			pslverr_o <= psel_i && !penable_i && !addr_ok;
		end
	end

endmodule : omr_fsm

// ===== sim/omr_fsm_sva.sv
// Port checker for the occupancy mode state control
module omr_fsm_sva
	import omr_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic motion_i,
	input wire logic manual_on_i,
	input wire logic manual_off_i,
	input wire logic supply_return_i,
	input wire omr_pkg::omr_tx_s tx_o,
	input wire logic presence_o,
	input wire logic detecting_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);
	ready_a: assert property (psel_i && !penable_i |=> pready_o)
		else $error("pready missing in access phase");
	ready_once_a: assert property (pready_o |=> !pready_o)
		else $error("pready held two cycles");
	err_ready_a: assert property (pslverr_o |-> pready_o)
		else $error("pslverr without pready");
	unmapped_a: assert property (pready_o |-> pslverr_o == (paddr_i > 8'h08 || paddr_i[1:0] != 2'h0))
		else $error("pslverr does not match address");
	start_level_a: assert property (tx_o.detect_start |-> detecting_o)
		else $error("start telegram without detection");
	end_level_a: assert property (tx_o.detect_end |-> !detecting_o)
		else $error("end telegram with detection still on");
	start_cause_a: assert property (tx_o.detect_start |-> $past(motion_i, 2) || $past(motion_i, 3)
		|| $past(motion_i, 4) || $past(manual_on_i))
		else $error("detection start without cause");
	restart_idle_a: assert property ($rose(supply_return_i) && !motion_i |-> ##4 !detecting_o && !presence_o)
		else $error("detection left active after supply return");
endmodule // omr_fsm_sva

bind omr_fsm omr_fsm_sva chk (.clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
	.prdata_o, .pready_o, .pslverr_o, .motion_i, .manual_on_i, .manual_off_i, .supply_return_i,
	.tx_o, .presence_o, .detecting_o);

// ===== sim/omr_bus_model.sv
// Bus side model: sends manual telegrams and counts output telegrams
module omr_bus_model
	import omr_pkg::*;
(
	input wire logic clk_i,
	input wire omr_pkg::omr_tx_s tx_i,
	output logic on_o,
	output logic off_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int start_n = 0;
	int end_n = 0;
	int dis_n = 0;
	int dis_end_n = 0;
	initial begin
		on_o = 1'b0;
		off_o = 1'b0;
	end
	always @(posedge clk_i) begin
		start_n += int'(tx_i.detect_start);
		end_n += int'(tx_i.detect_end);
		dis_n += int'(tx_i.disable_start);
		dis_end_n += int'(tx_i.disable_end);
	end
	task automatic send(input logic is_off);
		on_o <= !is_off;
		off_o <= is_off;
		@(posedge clk_i);
		on_o <= 1'b0;
		off_o <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask
endmodule // omr_bus_model

// ===== sim/occupancy_mode_and_restart_fsm_bench.sv
// Self-checking bench for the occupancy mode state control
module occupancy_mode_and_restart_fsm_bench import omr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, re;
	logic motion = 0, sup = 0, on, off, pres, det;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rq;
	omr_tx_s tx;
	int error_cnt = 0, checked = 0, n;
	omr_fsm #(.TICK_CYCLES(8)) dut (.clk_i(clk), .reset_n_i(rst_n), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .motion_i(motion), .manual_on_i(on), .manual_off_i(off),
		.supply_return_i(sup), .tx_o(tx), .presence_o(pres), .detecting_o(det));
	omr_bus_model bus (.clk_i(clk), .tx_i(tx), .on_o(on), .off_o(off));
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	function automatic logic [31:0] ctrl_w(omr_mode_e m, omr_app_e a, logic r, logic l, logic s);
		return {24'h0, s, l, l, r, a, m};
	endfunction
	task automatic summarize();
		$display("Checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", s, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic move(input int c);
		motion <= 1'b1;
		repeat (c) @(posedge clk);
		motion <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
	task automatic supply();
		sup <= 1'b1;
		repeat (4) @(posedge clk);
		sup <= 1'b0;
		repeat (6) @(posedge clk);
	endtask
	initial begin
		#60us;
		error_cnt++;
		summarize();
	end
	initial begin
		void'($urandom(69));
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		apb(0, OMR_CTRL_ADDR, 0);
		chk("ctrl reset", 0, rq);
		apb(0, OMR_HOLD_ADDR, 0);
		chk("hold reset", OMR_HOLD_RESET, rq);
		apb(0, 8'h0c, 0);
		chk("unmapped err", 1, re);
		apb(1, OMR_HOLD_ADDR, 32'h2);
		apb(1, OMR_CTRL_ADDR, ctrl_w(OMR_MODE_AUTO_START_MANUAL_END, OMR_APP_SINGLE, 0, 0, 0));
		n = bus.start_n;
		move($urandom_range(6, 3));
		chk("detect on motion", 1, det);
		chk("start telegram", n + 1, bus.start_n);
		repeat ($urandom_range(80, 40)) @(posedge clk);
		chk("no timeout", 1, det);
		bus.send(1);
		chk("manual off ends", 0, det);
		move($urandom_range(6, 3));
		chk("ready again", 1, det);
		bus.send(1);
		apb(1, OMR_CTRL_ADDR, ctrl_w(OMR_MODE_MANUAL_START_AUTO_END, OMR_APP_SINGLE, 0, 0, 0));
		apb(1, OMR_CTRL_ADDR, ctrl_w(OMR_MODE_AUTO_START_MANUAL_END, OMR_APP_SINGLE, 0, 1, 0));
		apb(0, OMR_CTRL_ADDR, 0);
		chk("mode kept", OMR_MODE_MANUAL_START_AUTO_END, rq[1:0]);
		move(4);
		chk("motion ignored", 0, det);
		bus.send(0);
		chk("on starts", 1, det);
		repeat (40) @(posedge clk);
		chk("timeout ends", 0, det);
		move(4);
		chk("stays off", 0, det);
		apb(1, OMR_CTRL_ADDR, ctrl_w(OMR_MODE_FULL_AUTO, OMR_APP_SINGLE, 1, 0, 1));
		n = bus.dis_n;
		supply();
		apb(0, OMR_STATUS_ADDR, 0);
		chk("disabled state", OMR_ST_DISABLED, rq[1:0]);
		chk("saved basic", OMR_ST_ARMED, rq[5:4]);
		chk("disable telegram", n + 1, bus.dis_n);
		n = bus.dis_end_n;
		apb(1, OMR_CTRL_ADDR, ctrl_w(OMR_MODE_FULL_AUTO, OMR_APP_MAIN, 0, 1, 0) | 32'h100);
		move(4);
		chk("disable end telegram", n + 1, bus.dis_end_n);
		chk("presence on", 1, pres);
		n = bus.end_n;
		supply();
		chk("basic after return", 0, det);
		chk("presence cleared", 0, pres);
		chk("no end telegram", n, bus.end_n);
		apb(1, OMR_CTRL_ADDR, ctrl_w(OMR_MODE_FULL_AUTO, OMR_APP_EXTENSION, 1, 0, 1));
		supply();
		apb(0, OMR_STATUS_ADDR, 0);
		chk("extension ignores", OMR_ST_ARMED, rq[1:0]);
		summarize();
	end
endmodule // occupancy_mode_and_restart_fsm_bench
